// ### src/oag_pkg.sv
package oag_pkg;

  localparam int ADDR_W = 16;

  // high byte forced onto page-zero addresses
  localparam logic [7:0] PAGE0_HI = 8'h00;

  // opcode high nibble: addressing form and instruction group
  localparam logic [3:0] HI_BITBR   = 4'h0;
  localparam logic [3:0] HI_BITMAN  = 4'h1;
  localparam logic [3:0] HI_RMW_DIR = 4'h3;
  localparam logic [3:0] HI_RMW_IX1 = 4'h6;
  localparam logic [3:0] HI_RMW_IX  = 4'h7;
  localparam logic [3:0] HI_RM_DIR  = 4'hb;
  localparam logic [3:0] HI_RM_EXT  = 4'hc;
  localparam logic [3:0] HI_RM_IX2  = 4'hd;
  localparam logic [3:0] HI_RM_IX1  = 4'he;
  localparam logic [3:0] HI_RM_IX   = 4'hf;

  // read-modify-write operation codes (opcode low nibble)
  localparam logic [3:0] OP_NEG = 4'h0;
  localparam logic [3:0] OP_COM = 4'h3;
  localparam logic [3:0] OP_LSR = 4'h4;
  localparam logic [3:0] OP_ROR = 4'h6;
  localparam logic [3:0] OP_ASR = 4'h7;
  localparam logic [3:0] OP_LSL = 4'h8;
  localparam logic [3:0] OP_ROL = 4'h9;
  localparam logic [3:0] OP_DEC = 4'ha;
  localparam logic [3:0] OP_INC = 4'hc;
  localparam logic [3:0] OP_TST = 4'hd;
  localparam logic [3:0] OP_CLR = 4'hf;

  // register/memory codes that are jumps
  localparam logic [3:0] OP_JMP = 4'hc;
  localparam logic [3:0] OP_JSR = 4'hd;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_IX    = 2'd1;
  localparam logic [1:0] LEN_DIR   = 2'd2;
  localparam logic [1:0] LEN_IX1   = 2'd2;
  localparam logic [1:0] LEN_EXT   = 2'd3;
  localparam logic [1:0] LEN_IX2   = 2'd3;
  localparam logic [1:0] LEN_BITBR = 2'd3;

  // distance from opcode to the next instruction of a bit branch
  localparam logic [ADDR_W-1:0] BITBR_STEP = 16'h0003;

  // reset values
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
  localparam logic [7:0]        RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_DIR,
    MODE_EXT,
    MODE_IX,
    MODE_IX1,
    MODE_IX2
  } oag_mode_t;

  typedef enum logic [2:0] {
    GRP_NONE,
    GRP_REGMEM,
    GRP_JUMP,
    GRP_RMW,
    GRP_BITMAN,
    GRP_BITBR
  } oag_group_t;

  typedef struct packed {
    oag_mode_t  mode;
    oag_group_t group;
    logic [3:0] op;
    logic [2:0] bitnum;
    logic       bit_clear;
    logic [1:0] len;
    logic       legal;
  } oag_dec_t;

endpackage

// ### src/oag_ea_calc.sv
`timescale 1ns/1ps
module oag_ea_calc #(
  parameter int AW = 16
) (
  input  oag_pkg::oag_mode_t mode,
  input  logic [7:0]         first_byte,
  input  logic [7:0]         second_byte,
  input  logic [7:0]         index_val,
  output logic [AW-1:0]      ea
);

  generate
    if (AW < 16) begin : g_chk
      $error("oag_ea_calc: address width below 16 bits");
    end
  endgenerate

  wire [AW-1:0] ea_dir;
  wire [AW-1:0] ea_ext;
  wire [AW-1:0] ea_ix;
  wire [AW-1:0] ea_ix1;
  wire [AW-1:0] ea_ix2;
  wire [8:0]    sum_ix1;
  wire [15:0]   sum_ix2;

  assign ea_dir  = AW'({oag_pkg::PAGE0_HI, first_byte});       // [RL1]
  assign ea_ext  = AW'({first_byte, second_byte});             // [RL4]
  assign ea_ix   = AW'({oag_pkg::PAGE0_HI, index_val});        // [RL6]
  // nine-bit sum keeps the carry, top result 0x01fe
  assign sum_ix1 = {1'b0, first_byte} + {1'b0, index_val};     // [RL8] [RL9]
  assign ea_ix1  = AW'(sum_ix1);                               // [RL9]
  // first byte is offset high, second is offset low
  assign sum_ix2 = {first_byte, second_byte} + {8'h00, index_val}; // [RL11] [RL12]
  assign ea_ix2  = AW'(sum_ix2);                               // [RL11]

  assign ea = (mode == oag_pkg::MODE_DIR) ? ea_dir :
              (mode == oag_pkg::MODE_EXT) ? ea_ext :
              (mode == oag_pkg::MODE_IX)  ? ea_ix  :
              (mode == oag_pkg::MODE_IX1) ? ea_ix1 :
              (mode == oag_pkg::MODE_IX2) ? ea_ix2 : AW'(0);

endmodule

// ### src/oag_top.sv
// Function
// RL1: direct address is the byte after opcode, high byte zero.
// RL2: ordinary direct instructions are two bytes long.
// RL3: bit-test-and-branch is three bytes: direct address, then displacement.
// RL4: extended address: first byte high, second byte low, any location.
// RL5: extended instructions are three bytes long.
// RL6: indexed no offset uses index as low byte, high byte zero.
// RL7: indexed no offset is a single opcode byte.
// RL8: 8-bit offset address is unsigned index plus unsigned offset byte.
// RL9: 8-bit offset sum keeps its carry, highest address 510.
// RL10: 8-bit offset indexed instructions are two bytes long.
// RL11: 16-bit offset address is index plus unsigned 16-bit word.
// RL12: 16-bit offset: first byte high, second byte low.
// RL13: 16-bit offset indexed instructions are three bytes long.
// RL14: direct accepts load/store/alu/jump/rmw/bit set-clear/bit branch.
// RL15: extended accepts register/memory and jumps only.
// RL16: no 16-bit offset form for read-modify-write operations.
// RL17: bit branch adds signed third byte to pc when bit matches.
// RL18: arithmetic and logical shift left decode as one operation.
`timescale 1ns/1ps
module oag_top #(
  parameter int AW = oag_pkg::ADDR_W
) (
  input  logic                 clk,
  input  logic                 rstn,
  input  logic                 fetch_valid,
  input  logic [7:0]           fetch_byte,
  input  logic [AW-1:0]        insn_addr,
  input  logic [7:0]           index_reg,
  input  logic                 tested_valid,
  input  logic                 tested_bit,
  output logic                 fetch_ready,
  output logic                 ea_valid,
  output logic [AW-1:0]        ea,
  output oag_pkg::oag_dec_t    ea_info,
  output logic                 unsupported,
  output logic                 insn_done,
  output logic                 branch_load,
  output logic [AW-1:0]        branch_target,
  output logic                 tested_carry
);

  generate
    if (AW != oag_pkg::ADDR_W) begin : g_chk
      $error("oag_top: address width must equal the package width");
    end
  endgenerate

  typedef enum logic [1:0] {
    ST_OPC,
    ST_OP1,
    ST_OP2,
    ST_TEST
  } oag_state_t;

  // read-modify-write codes that exist; the rest are holes
  function automatic logic rmw_op_ok(input logic [3:0] op);
    logic ok;
    ok = 1'b0;
    case (op)
      oag_pkg::OP_NEG,
      oag_pkg::OP_COM,
      oag_pkg::OP_LSR,
      oag_pkg::OP_ROR,
      oag_pkg::OP_ASR,
      oag_pkg::OP_LSL,
      oag_pkg::OP_ROL,
      oag_pkg::OP_DEC,
      oag_pkg::OP_INC,
      oag_pkg::OP_TST,
      oag_pkg::OP_CLR: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // which instruction groups each addressing form serves
  function automatic logic mode_accepts(input oag_pkg::oag_mode_t m,
                                        input oag_pkg::oag_group_t g);
    logic ok;
    ok = 1'b0;
    case (m)
      oag_pkg::MODE_DIR: begin
        ok = (g != oag_pkg::GRP_NONE);                      // [RL14]
      end
      oag_pkg::MODE_EXT: begin
        ok = (g == oag_pkg::GRP_REGMEM) ||
             (g == oag_pkg::GRP_JUMP);                      // [RL15]
      end
      oag_pkg::MODE_IX,
      oag_pkg::MODE_IX1: begin
        ok = (g == oag_pkg::GRP_REGMEM) ||
             (g == oag_pkg::GRP_JUMP) ||
             (g == oag_pkg::GRP_RMW);
      end
      oag_pkg::MODE_IX2: begin
        ok = (g == oag_pkg::GRP_REGMEM) ||
             (g == oag_pkg::GRP_JUMP);                      // [RL16]
      end
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic oag_pkg::oag_group_t regmem_group(input logic [3:0] op);
    oag_pkg::oag_group_t g;
    g = oag_pkg::GRP_REGMEM;
    if ((op == oag_pkg::OP_JMP) || (op == oag_pkg::OP_JSR)) begin
      g = oag_pkg::GRP_JUMP;
    end
    return g;
  endfunction

  function automatic oag_pkg::oag_group_t rmw_group(input logic [3:0] op);
    oag_pkg::oag_group_t g;
    g = rmw_op_ok(op) ? oag_pkg::GRP_RMW : oag_pkg::GRP_NONE;
    return g;
  endfunction

  function automatic oag_pkg::oag_dec_t decode_op(input logic [7:0] opc);
    oag_pkg::oag_dec_t d;
    d           = '0;
    d.mode      = oag_pkg::MODE_NONE;
    d.group     = oag_pkg::GRP_NONE;
    // one code for both shift-left names, in every form
    d.op        = opc[3:0];                                 // [RL18]
    d.bitnum    = opc[3:1];
    d.bit_clear = opc[0];
    case (opc[7:4])
      oag_pkg::HI_BITBR: begin
        d.mode  = oag_pkg::MODE_DIR;
        d.group = oag_pkg::GRP_BITBR;
        d.len   = oag_pkg::LEN_BITBR;                       // [RL3]
      end
      oag_pkg::HI_BITMAN: begin
        d.mode  = oag_pkg::MODE_DIR;
        d.group = oag_pkg::GRP_BITMAN;
        d.len   = oag_pkg::LEN_DIR;                         // [RL2]
      end
      oag_pkg::HI_RMW_DIR: begin
        d.mode  = oag_pkg::MODE_DIR;
        d.group = rmw_group(opc[3:0]);
        d.len   = oag_pkg::LEN_DIR;                         // [RL2]
      end
      oag_pkg::HI_RMW_IX1: begin
        d.mode  = oag_pkg::MODE_IX1;
        d.group = rmw_group(opc[3:0]);
        d.len   = oag_pkg::LEN_IX1;                         // [RL10]
      end
      oag_pkg::HI_RMW_IX: begin
        d.mode  = oag_pkg::MODE_IX;
        d.group = rmw_group(opc[3:0]);
        d.len   = oag_pkg::LEN_IX;                          // [RL7]
      end
      oag_pkg::HI_RM_DIR: begin
        d.mode  = oag_pkg::MODE_DIR;
        d.group = regmem_group(opc[3:0]);
        d.len   = oag_pkg::LEN_DIR;                         // [RL2]
      end
      oag_pkg::HI_RM_EXT: begin
        d.mode  = oag_pkg::MODE_EXT;
        d.group = regmem_group(opc[3:0]);
        d.len   = oag_pkg::LEN_EXT;                         // [RL5]
      end
      oag_pkg::HI_RM_IX2: begin
        d.mode  = oag_pkg::MODE_IX2;
        d.group = regmem_group(opc[3:0]);
        d.len   = oag_pkg::LEN_IX2;                         // [RL13]
      end
      oag_pkg::HI_RM_IX1: begin
        d.mode  = oag_pkg::MODE_IX1;
        d.group = regmem_group(opc[3:0]);
        d.len   = oag_pkg::LEN_IX1;                         // [RL10]
      end
      oag_pkg::HI_RM_IX: begin
        d.mode  = oag_pkg::MODE_IX;
        d.group = regmem_group(opc[3:0]);
        d.len   = oag_pkg::LEN_IX;                          // [RL7]
      end
      default: begin
        d.mode  = oag_pkg::MODE_NONE;
        d.group = oag_pkg::GRP_NONE;
        d.len   = 2'd0;
      end
    endcase
    d.legal = mode_accepts(d.mode, d.group);                // [RL14] [RL15] [RL16]
    return d;
  endfunction

  oag_state_t         state_ff;
  oag_state_t         nxt_state;
  oag_pkg::oag_dec_t  dec_ff;
  oag_pkg::oag_dec_t  nxt_dec;
  logic [7:0]         first_ff;
  logic [7:0]         nxt_first;
  logic [AW-1:0]      base_ff;
  logic [AW-1:0]      nxt_base;
  logic [AW-1:0]      pend_ff;
  logic [AW-1:0]      nxt_pend;
  logic               fetch_ready_ff;
  logic               nxt_fetch_ready;
  logic               ea_valid_ff;
  logic               nxt_ea_valid;
  logic [AW-1:0]      ea_ff;
  logic [AW-1:0]      nxt_ea;
  oag_pkg::oag_dec_t  ea_info_ff;
  oag_pkg::oag_dec_t  nxt_ea_info;
  logic               unsupported_ff;
  logic               nxt_unsupported;
  logic               insn_done_ff;
  logic               nxt_insn_done;
  logic               branch_load_ff;
  logic               nxt_branch_load;
  logic [AW-1:0]      branch_target_ff;
  logic [AW-1:0]      nxt_branch_target;
  logic               tested_carry_ff;
  logic               nxt_tested_carry;

  wire                     take;
  wire oag_pkg::oag_dec_t  dec_now;
  wire oag_pkg::oag_dec_t  dec_sel;
  wire [7:0]               calc_first;
  wire [AW-1:0]            calc_ea;
  wire [AW-1:0]            disp_ext;
  wire [AW-1:0]            br_dest;
  wire                     bit_match;
  wire                     last_byte_op1;

  // a byte moves only while the fetch side sees ready
  assign take          = fetch_valid && fetch_ready_ff;
  assign dec_now       = decode_op(fetch_byte);
  assign dec_sel       = (state_ff == ST_OPC) ? dec_now : dec_ff;
  assign calc_first    = (state_ff == ST_OP1) ? fetch_byte : first_ff;
  assign last_byte_op1 = (dec_ff.len == oag_pkg::LEN_DIR);  // [RL2] [RL10]
  // displacement is signed, counted from the next instruction
  assign disp_ext      = {{(AW-8){fetch_byte[7]}}, fetch_byte}; // [RL17]
  assign br_dest       = base_ff + oag_pkg::BITBR_STEP + disp_ext; // [RL17]
  // clear-type branches on a zero, set-type on a one
  assign bit_match     = tested_bit ^ dec_ff.bit_clear;     // [RL17]

  oag_ea_calc #(
    .AW (AW)
  ) u_ea (
    .mode        (dec_sel.mode),
    .first_byte  (calc_first),
    .second_byte (fetch_byte),
    .index_val   (index_reg),
    .ea          (calc_ea)
  );

  always_comb begin
    nxt_state         = state_ff;
    nxt_dec           = dec_ff;
    nxt_first         = first_ff;
    nxt_base          = base_ff;
    nxt_pend          = pend_ff;
    nxt_ea_valid      = 1'b0;
    nxt_ea            = ea_ff;
    nxt_ea_info       = ea_info_ff;
    nxt_unsupported   = 1'b0;
    nxt_insn_done     = 1'b0;
    nxt_branch_load   = 1'b0;
    nxt_branch_target = branch_target_ff;
    nxt_tested_carry  = tested_carry_ff;
    case (state_ff)
      ST_OPC: begin
        if (take) begin
          if (!dec_now.legal) begin
            nxt_unsupported = 1'b1;
          end else begin
            nxt_dec  = dec_now;
            nxt_base = insn_addr;
            if (dec_now.len == oag_pkg::LEN_IX) begin
              // no operand bytes: address straight from index
              nxt_ea        = calc_ea;                      // [RL6] [RL7]
              nxt_ea_valid  = 1'b1;
              nxt_ea_info   = dec_now;
              nxt_insn_done = 1'b1;
            end else begin
              nxt_state = ST_OP1;
            end
          end
        end
      end
      ST_OP1: begin
        if (take) begin
          nxt_first = fetch_byte;
          if (last_byte_op1) begin
            nxt_ea        = calc_ea;                        // [RL1] [RL8]
            nxt_ea_valid  = 1'b1;
            nxt_ea_info   = dec_ff;
            nxt_insn_done = 1'b1;
            nxt_state     = ST_OPC;
          end else begin
            nxt_state = ST_OP2;                             // [RL5] [RL13]
          end
        end
      end
      ST_OP2: begin
        if (take) begin
          // bit branch: held byte is the direct address
          nxt_ea       = calc_ea;                           // [RL3] [RL4] [RL11]
          nxt_ea_valid = 1'b1;
          nxt_ea_info  = dec_ff;
          if (dec_ff.group == oag_pkg::GRP_BITBR) begin
            nxt_pend  = br_dest;                            // [RL17]
            nxt_state = ST_TEST;
          end else begin
            nxt_insn_done = 1'b1;
            nxt_state     = ST_OPC;
          end
        end
      end
      ST_TEST: begin
        if (tested_valid) begin
          nxt_tested_carry  = tested_bit;
          nxt_branch_load   = bit_match;                    // [RL17]
          nxt_branch_target = pend_ff;
          nxt_insn_done     = 1'b1;
          nxt_state         = ST_OPC;
        end
      end
      default: begin
        nxt_state = ST_OPC;
      end
    endcase
    nxt_fetch_ready = (nxt_state != ST_TEST);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff         <= ST_OPC;
      dec_ff           <= '0;
      first_ff         <= oag_pkg::RST_BYTE;
      base_ff          <= oag_pkg::RST_ADDR;
      pend_ff          <= oag_pkg::RST_ADDR;
      fetch_ready_ff   <= 1'b0;
      ea_valid_ff      <= 1'b0;
      ea_ff            <= oag_pkg::RST_ADDR;
      ea_info_ff       <= '0;
      unsupported_ff   <= 1'b0;
      insn_done_ff     <= 1'b0;
      branch_load_ff   <= 1'b0;
      branch_target_ff <= oag_pkg::RST_ADDR;
      tested_carry_ff  <= 1'b0;
    end else begin
      state_ff         <= nxt_state;
      dec_ff           <= nxt_dec;
      first_ff         <= nxt_first;
      base_ff          <= nxt_base;
      pend_ff          <= nxt_pend;
      fetch_ready_ff   <= nxt_fetch_ready;
      ea_valid_ff      <= nxt_ea_valid;
      ea_ff            <= nxt_ea;
      ea_info_ff       <= nxt_ea_info;
      unsupported_ff   <= nxt_unsupported;
      insn_done_ff     <= nxt_insn_done;
      branch_load_ff   <= nxt_branch_load;
      branch_target_ff <= nxt_branch_target;
      tested_carry_ff  <= nxt_tested_carry;
    end
  end

  assign fetch_ready   = fetch_ready_ff;
  assign ea_valid      = ea_valid_ff;
  assign ea            = ea_ff;
  assign ea_info       = ea_info_ff;
  assign unsupported   = unsupported_ff;
  assign insn_done     = insn_done_ff;
  assign branch_load   = branch_load_ff;
  assign branch_target = branch_target_ff;
  assign tested_carry  = tested_carry_ff;

endmodule

// ### verification/oag_checker.sv
`timescale 1ns/1ps
module oag_checker #(
  parameter int AW = 16
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              fetch_valid,
  input wire logic [7:0]        fetch_byte,
  input wire logic [7:0]        index_reg,
  input wire logic              fetch_ready,
  input wire logic              ea_valid,
  input wire logic [AW-1:0]     ea,
  input wire oag_pkg::oag_dec_t ea_info,
  input wire logic              unsupported,
  input wire logic              insn_done,
  input wire logic              branch_load
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire ev = ea_valid;
  oag_pkg::oag_dec_t d;
  assign d = ea_info;

  dir_page0_a: assert property (ev && d.mode == oag_pkg::MODE_DIR &&
    d.group != oag_pkg::GRP_BITBR |-> ea == {8'h00, $past(fetch_byte)})
    else $error("direct address wrong");
  dir_len_a: assert property (ev && d.mode == oag_pkg::MODE_DIR &&
    d.group != oag_pkg::GRP_BITBR |-> d.len == oag_pkg::LEN_DIR)
    else $error("direct length wrong");
  bitbr_form_a: assert property (ev && d.group == oag_pkg::GRP_BITBR
    |-> d.mode == oag_pkg::MODE_DIR && d.len == oag_pkg::LEN_BITBR)
    else $error("bit branch form wrong");
  ext_form_a: assert property (ev && d.mode == oag_pkg::MODE_EXT
    |-> d.len == oag_pkg::LEN_EXT && (d.group == oag_pkg::GRP_REGMEM ||
    d.group == oag_pkg::GRP_JUMP))
    else $error("extended form wrong");
  ix_addr_a: assert property (ev && d.mode == oag_pkg::MODE_IX
    |-> ea == {8'h00, $past(index_reg)} && d.len == oag_pkg::LEN_IX)
    else $error("no offset address wrong");
  ix1_sum_a: assert property (ev && d.mode == oag_pkg::MODE_IX1
    |-> ea == {8'h00, $past(index_reg)} + {8'h00, $past(fetch_byte)})
    else $error("byte offset sum wrong");
  ix1_len_a: assert property (ev && d.mode == oag_pkg::MODE_IX1
    |-> d.len == oag_pkg::LEN_IX1)
    else $error("byte offset length wrong");
  ix2_form_a: assert property (ev && d.mode == oag_pkg::MODE_IX2
    |-> d.len == oag_pkg::LEN_IX2 && d.group != oag_pkg::GRP_RMW)
    else $error("word offset form wrong");
  legal_out_a: assert property (ev |-> d.legal && !unsupported)
    else $error("accepted opcode not legal");
  bitbr_wait_a: assert property (ev && d.group == oag_pkg::GRP_BITBR
    |-> !fetch_ready && !insn_done)
    else $error("bit branch did not wait");
  branch_done_a: assert property (branch_load |-> insn_done)
    else $error("branch without done");
endmodule
bind oag_top oag_checker #(.AW(AW)) u_chk (.clk(clk), .rstn(rstn),
  .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
  .index_reg(index_reg), .fetch_ready(fetch_ready), .ea_valid(ea_valid),
  .ea(ea), .ea_info(ea_info), .unsupported(unsupported),
  .insn_done(insn_done), .branch_load(branch_load));

// ### verification/oag_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module oag_top_tb;
  logic              clk, rstn, fetch_valid, tested_valid, tested_bit;
  logic [7:0]        fetch_byte, index_reg;
  logic [15:0]       insn_addr, ea, branch_target;
  logic              fetch_ready, ea_valid, unsupported, insn_done;
  logic              branch_load, tested_carry;
  oag_pkg::oag_dec_t ea_info;
  int                n_mismatch, checked;

  oag_top uut (.clk(clk), .rstn(rstn), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .insn_addr(insn_addr), .index_reg(index_reg),
    .tested_valid(tested_valid), .tested_bit(tested_bit),
    .fetch_ready(fetch_ready), .ea_valid(ea_valid), .ea(ea),
    .ea_info(ea_info), .unsupported(unsupported), .insn_done(insn_done),
    .branch_load(branch_load), .branch_target(branch_target),
    .tested_carry(tested_carry));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hold the byte until an edge sees fetch_ready high
  task automatic put(input logic [7:0] b);
    int i;
    fetch_valid <= 1'b1;
    fetch_byte  <= b;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (fetch_ready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      results();
    end
    @(posedge clk);
  endtask

  task automatic await;
    int i;
    for (i = 0; i < 10; i++) begin
      @(negedge clk);
      if ((ea_valid | unsupported | insn_done) === 1'b1) break;
    end
    if (i == 10) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic insn(input logic [7:0] b0, b1, b2, input int n,
                      input logic [7:0] idx, input logic [15:0] a, e,
                      input oag_pkg::oag_mode_t m,
                      input oag_pkg::oag_group_t g);
    @(posedge clk);
    index_reg <= idx;
    insn_addr <= a;
    put(b0);
    if (n > 1) put(b1);
    if (n > 2) put(b2);
    fetch_valid <= 1'b0;
    fetch_byte  <= ~b2;
    await();
    `CHK("ea", e, ea)
    `CHK("valid", 1'b1, ea_valid)
    `CHK("refused", 1'b0, unsupported)
    `CHK("mode", m, ea_info.mode)
    `CHK("group", g, ea_info.group)
    `CHK("len", 2'(n), ea_info.len)
    `CHK("done", g != oag_pkg::GRP_BITBR, insn_done)
  endtask

  task automatic t_reset;
    @(negedge clk);
    `CHK("rst ready", 1'b0, fetch_ready)
    `CHK("rst ea", 16'h0000, ea)
    `CHK("rst info", '0, ea_info)
    $display("test reset done");
  endtask

  task automatic t_dir;
    insn(8'hb6, 8'h7f, 0, 2, 8'h55, 0, 16'h007f, oag_pkg::MODE_DIR,
         oag_pkg::GRP_REGMEM);
    insn(8'hbc, 8'hff, 0, 2, 8'h01, 0, 16'h00ff, oag_pkg::MODE_DIR,
         oag_pkg::GRP_JUMP);
    insn(8'h1a, 8'h20, 0, 2, 8'h01, 0, 16'h0020, oag_pkg::MODE_DIR,
         oag_pkg::GRP_BITMAN);
    insn(8'h3c, 8'h00, 0, 2, 8'hff, 0, 16'h0000, oag_pkg::MODE_DIR,
         oag_pkg::GRP_RMW);
    $display("test direct done");
  endtask

  task automatic t_ext;
    insn(8'hc6, 8'h12, 8'h34, 3, 8'h77, 0, 16'h1234, oag_pkg::MODE_EXT,
         oag_pkg::GRP_REGMEM);
    insn(8'hcd, 8'hff, 8'hfe, 3, 8'h01, 0, 16'hfffe, oag_pkg::MODE_EXT,
         oag_pkg::GRP_JUMP);
    $display("test extended done");
  endtask

  task automatic t_idx;
    insn(8'hf6, 0, 0, 1, 8'hab, 0, 16'h00ab, oag_pkg::MODE_IX,
         oag_pkg::GRP_REGMEM);
    insn(8'he6, 8'hff, 0, 2, 8'hff, 0, 16'h01fe, oag_pkg::MODE_IX1,
         oag_pkg::GRP_REGMEM);
    insn(8'hd6, 8'h12, 8'h34, 3, 8'hff, 0, 16'h1333, oag_pkg::MODE_IX2,
         oag_pkg::GRP_REGMEM);
    insn(8'hdc, 8'hff, 8'hf0, 3, 8'h20, 0, 16'h0010, oag_pkg::MODE_IX2,
         oag_pkg::GRP_JUMP);
    insn(8'h6a, 8'h80, 0, 2, 8'h90, 0, 16'h0110, oag_pkg::MODE_IX1,
         oag_pkg::GRP_RMW);
    $display("test indexed done");
  endtask

  task automatic t_shift;
    insn(8'h38, 8'h44, 0, 2, 8'h02, 0, 16'h0044, oag_pkg::MODE_DIR,
         oag_pkg::GRP_RMW);
    `CHK("op dir", oag_pkg::OP_LSL, ea_info.op)
    insn(8'h68, 8'h44, 0, 2, 8'h02, 0, 16'h0046, oag_pkg::MODE_IX1,
         oag_pkg::GRP_RMW);
    `CHK("op ix1", oag_pkg::OP_LSL, ea_info.op)
    insn(8'h78, 0, 0, 1, 8'h02, 0, 16'h0002, oag_pkg::MODE_IX,
         oag_pkg::GRP_RMW);
    `CHK("op ix", oag_pkg::OP_LSL, ea_info.op)
    $display("test shift done");
  endtask

  task automatic t_bad;
    logic [7:0] ops [13] = '{8'h20, 8'h4f, 8'h5a, 8'h80, 8'h9c, 8'ha6,
                             8'h31, 8'h32, 8'h35, 8'h3b, 8'h3e, 8'h61, 8'h7e};
    foreach (ops[k]) begin
      @(posedge clk);
      put(ops[k]);
      fetch_valid <= 1'b0;
      await();
      `CHK("unsupported", 1'b1, unsupported)
      `CHK("no ea", 1'b0, ea_valid)
    end
    insn(8'hf6, 0, 0, 1, 8'h3c, 0, 16'h003c, oag_pkg::MODE_IX,
         oag_pkg::GRP_REGMEM);
    $display("test refused done");
  endtask

  task automatic t_bitbr;
    logic [7:0]  opc [3] = '{8'h03, 8'h0e, 8'h00};
    logic [7:0]  dsp [3] = '{8'hfe, 8'h10, 8'h7f};
    logic [15:0] adr [3] = '{16'h0100, 16'h0200, 16'hfffe};
    logic        tb  [3] = '{1'b0, 1'b0, 1'b1};
    logic [15:0] tgt;
    foreach (opc[k]) begin
      tgt = adr[k] + 16'h0003 + {{8{dsp[k][7]}}, dsp[k]};
      insn(opc[k], 8'h40, dsp[k], 3, 8'h11, adr[k], 16'h0040,
           oag_pkg::MODE_DIR, oag_pkg::GRP_BITBR);
      `CHK("bitnum", opc[k][3:1], ea_info.bitnum)
      `CHK("clear", opc[k][0], ea_info.bit_clear)
      `CHK("wait ready", 1'b0, fetch_ready)
      @(posedge clk);
      tested_valid <= 1'b1;
      tested_bit   <= tb[k];
      @(posedge clk);
      tested_valid <= 1'b0;
      await();
      `CHK("taken", tb[k] ^ opc[k][0], branch_load)
      `CHK("carry", tb[k], tested_carry)
      `CHK("ready", 1'b1, fetch_ready)
      if (tb[k] ^ opc[k][0]) `CHK("target", tgt, branch_target)
    end
    // a tested bit outside the wait must not branch
    @(posedge clk);
    tested_valid <= 1'b1;
    @(posedge clk);
    tested_valid <= 1'b0;
    @(negedge clk);
    `CHK("idle branch", 1'b0, branch_load)
    `CHK("idle done", 1'b0, insn_done)
    `CHK("idle ready", 1'b1, fetch_ready)
    $display("test bit branch done");
  endtask

  initial begin
    rstn = 1'b0;
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
    insn_addr = 16'h0000;
    index_reg = 8'h00;
    tested_valid = 1'b0;
    tested_bit = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    t_reset();
    @(posedge clk);
    rstn <= 1'b1;
    t_dir();
    t_ext();
    t_idx();
    t_shift();
    t_bad();
    t_bitbr();
    results();
  end
endmodule
